// [common/pmsc_cfg.svh]
`ifndef PMSC_CFG_SVH
`define PMSC_CFG_SVH

// ----------------------------------------------------------------------
// Flash security, clock, module gating and boot configuration
// ----------------------------------------------------------------------
`define PMSC_SEC_FIELD_ADDR    12'h40e
`define PMSC_SEC_UNSECURED     2'h2
`define PMSC_MOD_COUNT         16
`define PMSC_CLKSEL_W          2
`define PMSC_DIV_W             4
`define PMSC_GATE_RESET        16'hffff
`define PMSC_STOP_KEEP_MASK    16'h000f
`define PMSC_VERY_LOW_POWER_STOP_KEEP_MASK    16'h03ff
`define PMSC_VLP_DIV           4'h7
`define PMSC_BOOT_FLASH_ADDR   32'h00000000

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PMSC_CLK_MHZ           25
`define PMSC_WAKE_NS           200
`define PMSC_WAKE_CYCLES       ((`PMSC_WAKE_NS * `PMSC_CLK_MHZ + 999) / 1000)

`endif

// [common/pmsc_pkg.sv]
package pmsc_pkg;

  // --------------------------------------------------------------------
  // Operating modes, as reported on the status port
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    PMSC_RUN        = 3'h0,
    PMSC_VLP_RUN    = 3'h1,
    PMSC_WAIT       = 3'h2,
    PMSC_VLP_WAIT   = 3'h3,
    PMSC_STOP       = 3'h4,
    PMSC_VLP_STOP   = 3'h5,
    PMSC_WAKING     = 3'h6
  } pmsc_mode_t;

  typedef enum logic [1:0] {
    PMSC_CFG_WAIT      = 2'h0,
    PMSC_CFG_STOP      = 2'h1
  } pmsc_sleep_kind_t;

endpackage

// [rtl/pmsc_ctrl.sv]
`timescale 1ns/100ps
`include "pmsc_cfg.svh"


module pmsc_ctrl (
  input  wire logic                        i_clk,
  input  wire logic                        i_reset_n,
  input  wire logic                        i_sleep_req,
  input  wire logic                        i_cfg_stop,
  input  wire logic                        i_cfg_vlp,
  input  wire logic                        i_run_vlp,
  input  wire logic                        i_irq_pending,
  input  wire logic                        i_async_wake,
  input  wire logic [`PMSC_CLKSEL_W-1:0]   i_clk_src_sel,
  input  wire logic [`PMSC_DIV_W-1:0]      i_bus_div,
  input  wire logic [`PMSC_DIV_W-1:0]      i_flash_div,
  input  wire logic [`PMSC_MOD_COUNT-1:0]  i_module_gate_en,
  input  wire logic [1:0]                  i_sec_field,
  input  wire logic                        i_sec_field_valid,
  input  wire logic                        i_dbg_mem_req,
  input  wire logic                        i_dbg_mass_erase,
  input  wire logic                        i_erase_done,
  input  wire logic                        i_retain_analog,
  output logic [2:0]                       o_mode,
  output logic                             o_core_clk_en,
  output logic                             o_core_sleep,
  output logic [`PMSC_MOD_COUNT-1:0]       o_module_clk_en,
  output logic                             o_bus_master_tick,
  output logic                             o_bus_slave_tick,
  output logic                             o_flash_tick,
  output logic [`PMSC_CLKSEL_W-1:0]        o_clk_src,
  output logic                             o_lvd_en,
  output logic                             o_vec_irq_en,
  output logic                             o_async_wake_en,
  output logic                             o_retain_sram,
  output logic                             o_retain_regs,
  output logic                             o_analog_pd,
  output logic                             o_secure,
  output logic                             o_dbg_mem_grant,
  output logic                             o_erase_all_req,
  output logic [31:0]                      o_boot_addr,
  output logic                             o_boot_from_flash
);

  typedef struct packed {
    pmsc_pkg::pmsc_mode_t              mode;
    pmsc_pkg::pmsc_mode_t              sleep_from;
    logic [7:0]                        wake_cnt;
    logic                              core_clk_en;
    logic                              core_sleep;
    logic [`PMSC_MOD_COUNT-1:0]        module_clk_en;
    logic [`PMSC_CLKSEL_W-1:0]         clk_src;
    logic                              lvd_en;
    logic                              vec_irq_en;
    logic                              async_wake_en;
    logic                              retain_sram;
    logic                              retain_regs;
    logic                              analog_pd;
    logic                              secure;
    logic                              sec_loaded;
    logic                              dbg_mem_grant;
    logic                              erase_all_req;
    logic                              bus_tick;
    logic                              flash_tick;
    logic [2:0]                        wake_sync;
  } pmsc_state_t;

  localparam logic [7:0] WAKE_CYCLES = 8'(`PMSC_WAKE_CYCLES);

  pmsc_state_t state;
  pmsc_state_t next_state;
  logic        div_run;
  logic [`PMSC_DIV_W-1:0] bus_div_eff;
  logic [`PMSC_DIV_W-1:0] flash_div_eff;
  logic        bus_tick_raw;
  logic        flash_tick_raw;
  logic        wake_seen;

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  function automatic logic pmsc_is_vlp(input pmsc_pkg::pmsc_mode_t m);
    return (m == pmsc_pkg::PMSC_VLP_RUN) ||
           (m == pmsc_pkg::PMSC_VLP_WAIT) ||
           (m == pmsc_pkg::PMSC_VLP_STOP);
  endfunction

  function automatic logic [`PMSC_DIV_W-1:0] pmsc_slow(
    input logic [`PMSC_DIV_W-1:0] div,
    input logic                   vlp
  );
    // Floor on the divide ratio caps the low-power clock rate
    if (vlp && div < `PMSC_VLP_DIV) begin
      return `PMSC_VLP_DIV;
    end
    return div;
  endfunction

  // --------------------------------------------------------------------
  // Clock domain dividers
  // --------------------------------------------------------------------
  // Dividers stop in deep sleep: no master, slave or flash clocks there
  assign div_run = (state.mode != pmsc_pkg::PMSC_STOP) &&
                   (state.mode != pmsc_pkg::PMSC_VLP_STOP);
  assign bus_div_eff   = pmsc_slow(i_bus_div, pmsc_is_vlp(state.mode));
  assign flash_div_eff = pmsc_slow(i_flash_div, pmsc_is_vlp(state.mode));

  pmsc_divider u_bus_div (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_run     (div_run),
    .i_div     (bus_div_eff),
    .o_tick    (bus_tick_raw)
  );

  pmsc_divider u_flash_div (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_run     (div_run),
    .i_div     (flash_div_eff),
    .o_tick    (flash_tick_raw)
  );

  // Async wake passes three flops; change counts when last two are both high
  assign wake_seen = state.wake_sync[2] & state.wake_sync[1];

  // --------------------------------------------------------------------
  // Mode controller
  // --------------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_state.wake_sync = {state.wake_sync[1:0], i_async_wake};
    // Mask the tick already in flight when deep sleep is entered
    next_state.bus_tick = bus_tick_raw & div_run;
    next_state.flash_tick = flash_tick_raw & div_run;

    // Security loaded once from the flash field after reset
    if (i_sec_field_valid && !state.sec_loaded) begin
      next_state.secure = (i_sec_field != `PMSC_SEC_UNSECURED);
      next_state.sec_loaded = 1'b1;
    end
    if (i_erase_done) begin
      next_state.secure = 1'b0;
      next_state.erase_all_req = 1'b0;
    end
    if (i_dbg_mass_erase && !i_erase_done) begin
      next_state.erase_all_req = 1'b1;
    end
    // Secure from reset until loaded: deny access while field unknown
    next_state.dbg_mem_grant = i_dbg_mem_req && state.sec_loaded &&
                               !next_state.secure;

    unique case (state.mode)
      pmsc_pkg::PMSC_RUN,
      pmsc_pkg::PMSC_VLP_RUN: begin
        next_state.mode = i_run_vlp ? pmsc_pkg::PMSC_VLP_RUN
                                    : pmsc_pkg::PMSC_RUN;
        if (i_sleep_req) begin
          next_state.sleep_from = next_state.mode;
          if (i_cfg_stop) begin
            next_state.mode = i_cfg_vlp ? pmsc_pkg::PMSC_VLP_STOP
                                        : pmsc_pkg::PMSC_STOP;
          end else begin
            next_state.mode = i_cfg_vlp ? pmsc_pkg::PMSC_VLP_WAIT
                                        : pmsc_pkg::PMSC_WAIT;
          end
        end
      end
      pmsc_pkg::PMSC_WAIT,
      pmsc_pkg::PMSC_VLP_WAIT: begin
        if (i_irq_pending) begin
          next_state.mode = state.sleep_from;
        end
      end
      pmsc_pkg::PMSC_STOP,
      pmsc_pkg::PMSC_VLP_STOP: begin
        if (wake_seen) begin
          next_state.mode = pmsc_pkg::PMSC_WAKING;
          next_state.wake_cnt = WAKE_CYCLES;
        end
      end
      pmsc_pkg::PMSC_WAKING: begin
        // Clocks restart first; core released once they settle
        if (state.wake_cnt <= 8'h01) begin
          next_state.mode = state.sleep_from;
          next_state.wake_cnt = '0;
        end else begin
          next_state.wake_cnt = state.wake_cnt - 8'h01;
        end
      end
      default: begin
        next_state.mode = pmsc_pkg::PMSC_RUN;
      end
    endcase

    // Outputs per mode, derived from the next mode
    next_state.clk_src = i_clk_src_sel;
    next_state.core_clk_en = 1'b1;
    next_state.core_sleep = 1'b0;
    next_state.module_clk_en = i_module_gate_en;
    next_state.lvd_en = 1'b1;
    next_state.vec_irq_en = 1'b1;
    next_state.async_wake_en = 1'b0;
    next_state.retain_sram = 1'b1;
    next_state.retain_regs = 1'b1;
    next_state.analog_pd = 1'b0;
    unique case (next_state.mode)
      pmsc_pkg::PMSC_RUN: begin
        next_state.module_clk_en = i_module_gate_en;
      end
      pmsc_pkg::PMSC_VLP_RUN: begin
        next_state.lvd_en = 1'b0;
      end
      pmsc_pkg::PMSC_WAIT: begin
        next_state.core_clk_en = 1'b0;
        next_state.core_sleep = 1'b1;
      end
      pmsc_pkg::PMSC_VLP_WAIT: begin
        next_state.core_clk_en = 1'b0;
        next_state.core_sleep = 1'b1;
        next_state.lvd_en = 1'b0;
      end
      pmsc_pkg::PMSC_STOP: begin
        next_state.core_clk_en = 1'b0;
        next_state.core_sleep = 1'b1;
        next_state.module_clk_en = i_module_gate_en &
                                   `PMSC_STOP_KEEP_MASK;
        next_state.lvd_en = 1'b1;
        next_state.retain_regs = 1'b1;
        next_state.vec_irq_en = 1'b0;
        next_state.async_wake_en = 1'b1;
        next_state.analog_pd = !i_retain_analog;
      end
      pmsc_pkg::PMSC_VLP_STOP: begin
        next_state.core_clk_en = 1'b0;
        next_state.core_sleep = 1'b1;
        next_state.module_clk_en = i_module_gate_en &
                                   `PMSC_VERY_LOW_POWER_STOP_KEEP_MASK;
        next_state.lvd_en = 1'b0;
        next_state.vec_irq_en = 1'b0;
        next_state.async_wake_en = 1'b1;
        next_state.retain_sram = 1'b1;
        next_state.analog_pd = !i_retain_analog;
      end
      pmsc_pkg::PMSC_WAKING: begin
        // Core held asleep until clocks are back; irq then serviced
        next_state.core_clk_en = 1'b0;
        next_state.core_sleep = 1'b1;
      end
      default: begin
        next_state.core_clk_en = 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= '0;
      state.mode <= pmsc_pkg::PMSC_RUN;
      state.sleep_from <= pmsc_pkg::PMSC_RUN;
      state.core_clk_en <= 1'b1;
      state.module_clk_en <= `PMSC_GATE_RESET;
      state.lvd_en <= 1'b1;
      state.vec_irq_en <= 1'b1;
      state.retain_sram <= 1'b1;
      state.retain_regs <= 1'b1;
      state.secure <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  assign o_mode            = state.mode;
  assign o_core_clk_en     = state.core_clk_en;
  assign o_core_sleep      = state.core_sleep;
  assign o_module_clk_en   = state.module_clk_en;
  assign o_bus_master_tick = state.bus_tick;
  assign o_bus_slave_tick  = state.bus_tick;
  assign o_flash_tick      = state.flash_tick;
  assign o_clk_src         = state.clk_src;
  assign o_lvd_en          = state.lvd_en;
  assign o_vec_irq_en      = state.vec_irq_en;
  assign o_async_wake_en   = state.async_wake_en;
  assign o_retain_sram     = state.retain_sram;
  assign o_retain_regs     = state.retain_regs;
  assign o_analog_pd       = state.analog_pd;
  assign o_secure          = state.secure;
  assign o_dbg_mem_grant   = state.dbg_mem_grant;
  assign o_erase_all_req   = state.erase_all_req;
  // Fixed vector: no other boot source exists
  assign o_boot_addr       = `PMSC_BOOT_FLASH_ADDR;
  assign o_boot_from_flash = 1'b1;

endmodule // pmsc_ctrl

// [rtl/pmsc_divider.sv]
`timescale 1ns/100ps
`include "pmsc_cfg.svh"

module pmsc_divider (
  input  wire logic                     i_clk,
  input  wire logic                     i_reset_n,
  input  wire logic                     i_run,
  input  wire logic [`PMSC_DIV_W-1:0]   i_div,
  output logic                          o_tick
);

  typedef struct packed {
    logic [`PMSC_DIV_W-1:0] count;
    logic                   tick;
  } pmsc_div_state_t;

  pmsc_div_state_t state;
  pmsc_div_state_t next_state;

  // --------------------------------------------------------------------
  // Divider: one tick every i_div+1 cycles
  // --------------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_state.tick = 1'b0;
    if (!i_run) begin
      next_state.count = '0;
    end else if (state.count >= i_div) begin
      next_state.count = '0;
      next_state.tick = 1'b1;
    end else begin
      next_state.count = state.count + 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign o_tick = state.tick;

endmodule // pmsc_divider

// [tb/pmsc_ctrl_asserts.sv]
`timescale 1ns/100ps
`include "pmsc_cfg.svh"

module pmsc_ctrl_asserts (
  input wire logic                       i_clk,
  input wire logic                       i_reset_n,
  input wire logic                       i_sleep_req,
  input wire logic                       i_cfg_stop,
  input wire logic                       i_cfg_vlp,
  input wire logic                       i_irq_pending,
  input wire logic                       i_async_wake,
  input wire logic [`PMSC_MOD_COUNT-1:0] i_module_gate_en,
  input wire logic                       i_erase_done,
  input wire logic [2:0]                 o_mode,
  input wire logic                       o_core_clk_en,
  input wire logic                       o_core_sleep,
  input wire logic [`PMSC_MOD_COUNT-1:0] o_module_clk_en,
  input wire logic                       o_bus_master_tick,
  input wire logic                       o_flash_tick,
  input wire logic                       o_lvd_en,
  input wire logic                       o_vec_irq_en,
  input wire logic                       o_async_wake_en,
  input wire logic                       o_retain_sram,
  input wire logic                       o_secure,
  input wire logic                       o_dbg_mem_grant,
  input wire logic                       o_erase_all_req,
  input wire logic [31:0]                o_boot_addr,
  input wire logic                       o_boot_from_flash
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  // ------------------------------------------------------------
  // Mode sequencing, gating, ticks, security and boot
  // ------------------------------------------------------------
  AST_SLEEP_ENTRY: assert property (
    (o_mode <= 3'h1) && i_sleep_req |=>
      o_mode == 3'h2 + {1'b0, $past(i_cfg_stop), $past(i_cfg_vlp)})
    else $error("sleep request entered the wrong mode");
  AST_WAIT_WAKE: assert property (
    (o_mode inside {3'h2, 3'h3}) && i_irq_pending |=> o_mode <= 3'h1)
    else $error("wait mode did not wake on interrupt");
  AST_STOP_PORTS: assert property (
    (o_mode inside {3'h4, 3'h5}) |->
      !o_vec_irq_en && o_async_wake_en && !o_core_clk_en && o_core_sleep)
    else $error("stop mode wake path or core state wrong");
  AST_WAKE_SYNC: assert property (
    (o_mode inside {3'h4, 3'h5}) && $rose(i_async_wake) |->
      ##[1:5] o_mode == 3'h6)
    else $error("async wake did not restart clocks in time");
  AST_WAKING_LEN: assert property (
    $rose(o_mode == 3'h6) |-> (o_mode == 3'h6) [*5] ##1 (o_mode <= 3'h1))
    else $error("clock restart phase has wrong length");
  AST_CORE_RUN: assert property (
    (o_mode <= 3'h1) |-> o_core_clk_en && !o_core_sleep)
    else $error("core not active in a run mode");
  // Skip the edge after reset, when gates still hold reset value
  AST_RUN_GATE: assert property (
    (o_mode <= 3'h3) && ($past(o_mode) <= 3'h3) && $past(i_reset_n) |->
      o_module_clk_en == $past(i_module_gate_en))
    else $error("module gates do not follow requests");
  AST_STOP_GATE: assert property (
    o_mode == 3'h4 && $past(o_mode) == 3'h4 |->
      o_module_clk_en == ($past(i_module_gate_en) & `PMSC_STOP_KEEP_MASK))
    else $error("stop mode gate mask wrong");
  AST_LVD: assert property (
    o_mode != 3'h6 |-> o_lvd_en == !o_mode[0] && o_retain_sram)
    else $error("voltage detect or retention wrong for mode");
  AST_NO_TICK: assert property (
    (o_mode inside {3'h4, 3'h5}) && ($past(o_mode) inside {3'h4, 3'h5})
      |-> !o_bus_master_tick && !o_flash_tick)
    else $error("clock tick seen in stop mode");
  AST_SECURE: assert property (
    o_secure |-> !o_dbg_mem_grant)
    else $error("debug access granted while secured");
  AST_ERASE: assert property (
    o_erase_all_req && i_erase_done |=> !o_secure && !o_erase_all_req)
    else $error("erase completion did not unsecure");
  AST_BOOT: assert property (
    o_boot_from_flash && o_boot_addr == `PMSC_BOOT_FLASH_ADDR)
    else $error("boot not from internal flash");

  COV_STOP: cover property (o_mode == 3'h5);
  COV_WAKING: cover property ($rose(o_mode == 3'h6));
  COV_GRANT: cover property ($rose(o_dbg_mem_grant));
endmodule // pmsc_ctrl_asserts

// [tb/pmsc_dbg_model.sv]
`timescale 1ns/100ps

module pmsc_dbg_model (
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  input  wire logic       i_start,
  input  wire logic [3:0] i_delay,
  input  wire logic       i_erase_all_req,
  output logic            o_mass_erase,
  output logic            o_erase_done
);
  logic [3:0] cnt;

  // ------------------------------------------------------------
  // Debugger mailbox and flash erase engine
  // ------------------------------------------------------------
  // Erase time is programmable so both prompt and slow flash are seen
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_mass_erase <= 1'b0;
      o_erase_done <= 1'b0;
      cnt          <= 4'h0;
    end else begin
      o_mass_erase <= i_start;
      o_erase_done <= 1'b0;
      if (!i_erase_all_req || o_erase_done) begin
        cnt <= 4'h0;
      end else if (cnt == i_delay) begin
        o_erase_done <= 1'b1;
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule // pmsc_dbg_model

// [tb/tb.sv]
`timescale 1ns/100ps
`include "pmsc_cfg.svh"

module tb;
  // ------------------------------------------------------------
  // Stimulus and observed ports
  // ------------------------------------------------------------
  logic        i_clk = 1'b0;
  logic        i_reset_n = 1'b1;
  logic        i_sleep_req = 1'b0;
  logic        i_cfg_stop = 1'b0;
  logic        i_cfg_vlp = 1'b0;
  logic        i_run_vlp = 1'b0;
  logic        i_irq_pending = 1'b0;
  logic        i_async_wake = 1'b0;
  logic [1:0]  i_clk_src_sel = 2'h0;
  logic [3:0]  i_bus_div = 4'h0;
  logic [3:0]  i_flash_div = 4'h0;
  logic [15:0] i_module_gate_en = 16'ha5c3;
  logic [1:0]  i_sec_field = 2'h0;
  logic        i_sec_field_valid = 1'b0;
  logic        i_dbg_mem_req = 1'b0;
  logic        i_retain_analog = 1'b0;
  logic        dbg_start = 1'b0;
  logic [3:0]  erase_delay = 4'h0;
  logic        i_dbg_mass_erase, i_erase_done;
  logic [2:0]  o_mode;
  logic [1:0]  o_clk_src;
  logic [15:0] o_module_clk_en;
  logic [31:0] o_boot_addr;
  logic        o_core_clk_en, o_core_sleep, o_bus_master_tick;
  logic        o_bus_slave_tick, o_flash_tick, o_lvd_en, o_vec_irq_en;
  logic        o_async_wake_en, o_retain_sram, o_retain_regs, o_analog_pd;
  logic        o_secure, o_dbg_mem_grant, o_erase_all_req;
  logic        o_boot_from_flash;
  int          failures = 0;
  int          cmp_count = 0;
  int          cyc = 0;

  pmsc_ctrl pmsc_ctrl_inst (.i_clk, .i_reset_n, .i_sleep_req, .i_cfg_stop,
    .i_cfg_vlp, .i_run_vlp, .i_irq_pending, .i_async_wake, .i_clk_src_sel,
    .i_bus_div, .i_flash_div, .i_module_gate_en, .i_sec_field,
    .i_sec_field_valid, .i_dbg_mem_req, .i_dbg_mass_erase, .i_erase_done,
    .i_retain_analog, .o_mode, .o_core_clk_en, .o_core_sleep,
    .o_module_clk_en, .o_bus_master_tick, .o_bus_slave_tick, .o_flash_tick,
    .o_clk_src, .o_lvd_en, .o_vec_irq_en, .o_async_wake_en, .o_retain_sram,
    .o_retain_regs, .o_analog_pd, .o_secure, .o_dbg_mem_grant,
    .o_erase_all_req, .o_boot_addr, .o_boot_from_flash);

  pmsc_dbg_model pmsc_dbg_model_inst (.i_clk, .i_reset_n,
    .i_start(dbg_start), .i_delay(erase_delay),
    .i_erase_all_req(o_erase_all_req), .o_mass_erase(i_dbg_mass_erase),
    .o_erase_done(i_erase_done));

  always #20 i_clk = ~i_clk;

  // Cuts a hang short well past the longest expected run
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      failures++;
      results();
    end
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic results();
    $display("checks %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, exp, input string nm);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic wait_mode(input logic [2:0] m);
    int k;
    k = 0;
    while (o_mode !== m && k < 12) begin
      step(1);
      k++;
    end
    chk(o_mode, m, "mode");
  endtask

  task automatic do_reset();
    @(posedge i_clk);
    i_reset_n <= 1'b0;
    i_sec_field_valid <= 1'b0;
    step(10);
    chk(o_mode, 3'h0, "reset mode");
    chk(o_module_clk_en, `PMSC_GATE_RESET, "reset gates");
    chk(o_secure, 1'b1, "reset secure");
    chk(o_boot_from_flash, 1'b1, "boot flash");
    chk(o_boot_addr, `PMSC_BOOT_FLASH_ADDR, "boot addr");
    @(posedge i_clk);
    i_reset_n <= 1'b1;
  endtask

  task automatic sleep(input logic stop, input logic vlp);
    @(posedge i_clk);
    i_cfg_stop  <= stop;
    i_cfg_vlp   <= vlp;
    i_sleep_req <= 1'b1;
    @(posedge i_clk);
    i_sleep_req <= 1'b0;
    #1;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_wait(input logic vlp);
    sleep(1'b0, vlp);
    wait_mode({2'h1, vlp});
    chk(o_core_sleep, 1'b1, "core sleep");
    chk(o_lvd_en, !vlp, "wait lvd");
    chk(o_vec_irq_en, 1'b1, "vec irq");
    sleep(1'b1, 1'b0);
    step(2);
    chk(o_mode, {2'h1, vlp}, "sleep refused");
    @(posedge i_clk);
    i_irq_pending <= 1'b1;
    @(posedge i_clk);
    i_irq_pending <= 1'b0;
    #1;
    chk(o_mode, {2'h0, i_run_vlp}, "wait wake");
  endtask

  task automatic t_stop(input logic vlp, input logic ret);
    @(posedge i_clk);
    i_retain_analog  <= ret;
    i_module_gate_en <= 16'h5a3c;
    sleep(1'b1, vlp);
    wait_mode({2'h2, vlp});
    step(2);
    chk(o_module_clk_en, 16'h5a3c & (vlp ? `PMSC_VERY_LOW_POWER_STOP_KEEP_MASK
        : `PMSC_STOP_KEEP_MASK), "stop gates");
    chk(o_vec_irq_en, 1'b0, "stop vec irq");
    chk(o_async_wake_en, 1'b1, "async wake en");
    chk(o_lvd_en, !vlp, "stop lvd");
    chk({o_retain_sram, o_retain_regs}, 2'h3, "retain");
    chk(o_analog_pd, !ret, "analog pd");
    @(posedge i_clk);
    i_irq_pending <= 1'b1;
    step(3);
    chk(o_mode, {2'h2, vlp}, "irq ignored");
    @(posedge i_clk);
    i_irq_pending <= 1'b0;
    i_async_wake  <= 1'b1;
    wait_mode(3'h6);
    @(posedge i_clk);
    i_async_wake <= 1'b0;
    wait_mode({2'h0, i_run_vlp});
  endtask

  task automatic t_run(input logic vlp);
    logic [4:0] nm, ns, nf;
    @(posedge i_clk);
    i_run_vlp     <= vlp;
    i_bus_div     <= 4'h1;
    i_flash_div   <= 4'h1;
    i_clk_src_sel <= {vlp, 1'b1};
    wait_mode({2'h0, vlp});
    chk(o_lvd_en, !vlp, "run lvd");
    chk(o_clk_src, {vlp, 1'b1}, "clk src");
    step(8);
    nm = 5'h0;
    ns = 5'h0;
    nf = 5'h0;
    repeat (16) begin
      step(1);
      nm = nm + o_bus_master_tick;
      ns = ns + o_bus_slave_tick;
      nf = nf + o_flash_tick;
    end
    // Divide of 1 gives 8 ticks in 16 cycles, floor of 7 gives 2
    chk(nm, vlp ? 5'h2 : 5'h8, "master ticks");
    chk(ns, vlp ? 5'h2 : 5'h8, "slave ticks");
    chk(nf, vlp ? 5'h2 : 5'h8, "flash ticks");
  endtask

  task automatic t_sec(input logic [1:0] field, input logic [3:0] dly);
    int k;
    do_reset();
    @(posedge i_clk);
    i_dbg_mem_req <= 1'b1;
    erase_delay   <= dly;
    step(2);
    chk(o_dbg_mem_grant, 1'b0, "grant unloaded");
    @(posedge i_clk);
    i_sec_field       <= field;
    i_sec_field_valid <= 1'b1;
    @(posedge i_clk);
    i_sec_field <= ~field;
    step(3);
    chk(o_secure, field != 2'h2, "secure");
    chk(o_dbg_mem_grant, field == 2'h2, "grant");
    if (field != 2'h2) begin
      @(posedge i_clk);
      dbg_start <= 1'b1;
      @(posedge i_clk);
      dbg_start <= 1'b0;
      k = 0;
      while (o_secure !== 1'b0 && k < 20) begin
        step(1);
        k++;
      end
      chk(o_secure, 1'b0, "unsecured");
      chk(o_erase_all_req, 1'b0, "erase req");
      step(1);
      chk(o_dbg_mem_grant, 1'b1, "grant after erase");
    end
  endtask

  initial begin
    #1 i_reset_n = 1'b0;
    do_reset();
    t_wait(1'b0);
    t_stop(1'b0, 1'b0);
    t_stop(1'b1, 1'b1);
    t_run(1'b1);
    t_wait(1'b1);
    t_stop(1'b0, 1'b1);
    t_run(1'b0);
    t_sec(2'h1, 4'h0);
    t_sec(2'h1, 4'h6);
    t_sec(2'h2, 4'h0);
    results();
  end
endmodule // tb

bind pmsc_ctrl pmsc_ctrl_asserts pmsc_ctrl_asserts_inst (.i_clk, .i_reset_n,
  .i_sleep_req, .i_cfg_stop, .i_cfg_vlp, .i_irq_pending, .i_async_wake,
  .i_module_gate_en, .i_erase_done, .o_mode, .o_core_clk_en, .o_core_sleep,
  .o_module_clk_en, .o_bus_master_tick, .o_flash_tick, .o_lvd_en,
  .o_vec_irq_en, .o_async_wake_en, .o_retain_sram, .o_secure,
  .o_dbg_mem_grant, .o_erase_all_req, .o_boot_addr, .o_boot_from_flash);
